// File: otpc_ctrl.v
// Host-side controller for the OTP area of a NAND target: sequencer, guards and pins.
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "otpc_regs.vh"
module otpc_ctrl (
	// Clock and reset.
	input wire ref_clk,
	input wire rst_b,
	// APB slave.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// NAND pins.
	output wire ce_n,
	output wire cle,
	output wire ale,
	output wire we_n,
	output wire re_n,
	output wire wp_n,
	output wire [7:0] dq_o,
	output wire dq_oe,
	input wire [7:0] dq_i,
	input wire rb_n
);
	localparam [3:0] S_IDLE = 4'b0001; // Waiting for software.
	localparam [3:0] S_ISSUE = 4'b0010; // Decoding the next step.
	localparam [3:0] S_XFER = 4'b0100; // A bus cycle is running.
	localparam [3:0] S_BUSY = 4'b1000; // Waiting for ready/busy to rise.
	localparam integer WB_N = `OTPC_BUSY_START_CYC - 1; // Busy-start delay minus one.
	localparam [3:0] WB_LAST = WB_N[3:0]; // Cut to the countdown width.

	wire [3:0] op; // Requested operation.
	wire go; // Start pulse.
	wire [15:0] col; // Column address.
	wire [7:0] page; // OTP page address.
	wire [31:0] wdata; // Bytes to program, byte 0 first.
	wire [2:0] len; // Byte count, 1 to 4.
	wire cg_busy; // Bus cycle engine is occupied.
	wire cg_done; // Bus cycle finished.
	wire [7:0] cg_rbyte; // Byte read by the last cycle.
	reg [3:0] state_ff; // Sequencer state.
	reg [3:0] nxt_state;
	reg [4:0] idx_ff; // Step index within the operation.
	reg [3:0] op_ff; // Operation being run.
	reg [3:0] wb_ff; // Busy-start countdown.
	reg otp_mode_ff; // Target believed to be in OTP mode.
	reg protected_ff; // Area known to be protected.
	reg refused_ff; // Last request refused by the guards.
	reg done_ff; // Last operation finished.
	reg [7:0] nand_stat_ff; // Last status byte from 70h.
	reg [31:0] rdata_ff; // Bytes read from the page, byte 0 low.
	reg [7:0] last_page_ff; // Highest page programmed so far.
	reg [3:0] part_cnt_ff; // Partial programs on that page.
	reg prog_seen_ff; // At least one page has been programmed.
	reg [2:0] kind; // Step kind.
	reg [7:0] sbyte; // Byte driven by the step.
	reg is_stat; // The read step fetches the status byte.
	reg [7:0] abyte; // Address byte for the current index.
	reg [2:0] didx; // Data byte index.
	reg refuse; // Request fails the guards.
	reg needs_otp; // Request only makes sense in OTP mode.

	// The register block answers software and stores the request.
	otpc_apb_regs u_regs (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.op_ff(op),
		.go_ff(go),
		.col_ff(col),
		.page_ff(page),
		.wdata_ff(wdata),
		.len_ff(len),
		.stat({nand_stat_ff, last_page_ff, part_cnt_ff, 7'h00, protected_ff, refused_ff,
			done_ff, otp_mode_ff, ~state_ff[0]}),
		.rdata(rdata_ff)
	);

	// The bus cycle engine shapes every strobe on the pins.
	otpc_bus_cycle u_cycle (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.start(state_ff[1] && kind < `OTPC_K_WAIT),
		.kind(kind),
		.wbyte(sbyte),
		.busy(cg_busy),
		.done_ff(cg_done),
		.rbyte_ff(cg_rbyte),
		.cle_ff(cle),
		.ale_ff(ale),
		.we_n_ff(we_n),
		.re_n_ff(re_n),
		.dq_o_ff(dq_o),
		.dq_oe_ff(dq_oe),
		.dq_i(dq_i)
	);

	// The chip stays selected for the whole operation; write protect is never asserted.
	assign ce_n = state_ff[0];
	assign wp_n = 1'b1;

	// Five address cycles: two column bytes, the page, then a block address of zero.
	always @* begin
		abyte = `OTPC_BYTE_ZERO;
		case (idx_ff)
			5'd1: abyte = (op_ff == `OTPC_OP_PROT) ? `OTPC_BYTE_ZERO : col[7:0];
			5'd2: abyte = (op_ff == `OTPC_OP_PROT) ? `OTPC_BYTE_ZERO : col[15:8];
			5'd3: abyte = (op_ff == `OTPC_OP_PROT) ? `OTPC_PROT_PAGE : page;
			default: abyte = `OTPC_BYTE_ZERO;
		endcase
	end

	// Step table: what the sequencer does at each index of each operation.
	// Data phases have a software-set length, so their indices shift what follows.
	always @* begin
		kind = `OTPC_K_END;
		sbyte = `OTPC_BYTE_ZERO;
		is_stat = 1'b0;
		didx = 3'h0;
		case (op_ff)
			`OTPC_OP_ENTER, `OTPC_OP_EXIT: begin
				// Set features to the OTP feature address; only P1 differs.
				if (idx_ff == 5'd0) begin
					kind = `OTPC_K_CMD;
					sbyte = `OTPC_CMD_SETFEAT;
				end else if (idx_ff == 5'd1) begin
					kind = `OTPC_K_ADDR;
					sbyte = `OTPC_FEAT_OTP;
				end else if (idx_ff == 5'd2) begin
					kind = `OTPC_K_DIN;
					sbyte = (op_ff == `OTPC_OP_ENTER) ? `OTPC_P1_ON : `OTPC_BYTE_ZERO;
				end else if (idx_ff < 5'd6) begin
					kind = `OTPC_K_DIN;
				end else if (idx_ff == 5'd6) begin
					kind = `OTPC_K_WAIT;
				end
			end
			`OTPC_OP_RESET, `OTPC_OP_SRESET: begin
				if (idx_ff == 5'd0) begin
					kind = `OTPC_K_CMD;
					sbyte = (op_ff == `OTPC_OP_RESET) ? `OTPC_CMD_RESET : `OTPC_CMD_SRESET;
				end else if (idx_ff == 5'd1) begin
					kind = `OTPC_K_WAIT;
				end
			end
			`OTPC_OP_STAT: begin
				// Plain status only; the enhanced form is never produced.
				if (idx_ff == 5'd0) begin
					kind = `OTPC_K_CMD;
					sbyte = `OTPC_CMD_STATUS;
				end else if (idx_ff == 5'd1) begin
					kind = `OTPC_K_DOUT;
					is_stat = 1'b1;
				end
			end
			`OTPC_OP_READ: begin
				if (idx_ff == 5'd0) begin
					kind = `OTPC_K_CMD;
					sbyte = `OTPC_CMD_READ;
				end else if (idx_ff < 5'd6) begin
					kind = `OTPC_K_ADDR;
					sbyte = abyte;
				end else if (idx_ff == 5'd6) begin
					kind = `OTPC_K_CMD;
					sbyte = `OTPC_CMD_READ_GO;
				end else if (idx_ff == 5'd7) begin
					kind = `OTPC_K_WAIT;
				end else if (idx_ff == 5'd8) begin
					kind = `OTPC_K_CMD;
					sbyte = `OTPC_CMD_STATUS;
				end else if (idx_ff == 5'd9) begin
					kind = `OTPC_K_DOUT;
					is_stat = 1'b1;
				end else if (idx_ff == 5'd10) begin
					// Leaves status output so data starts at the addressed column.
					kind = `OTPC_K_CMD;
					sbyte = `OTPC_CMD_READ;
				end else if (idx_ff < 5'd11 + {2'b00, len}) begin
					kind = `OTPC_K_DOUT;
					didx = idx_ff[2:0] - 3'd3;
				end
			end
			`OTPC_OP_COLRD: begin
				// Random column within the page already in the cache register.
				if (idx_ff == 5'd0) begin
					kind = `OTPC_K_CMD;
					sbyte = `OTPC_CMD_COLRD;
				end else if (idx_ff < 5'd3) begin
					kind = `OTPC_K_ADDR;
					sbyte = abyte;
				end else if (idx_ff == 5'd3) begin
					kind = `OTPC_K_CMD;
					sbyte = `OTPC_CMD_COLRD_GO;
				end else if (idx_ff < 5'd4 + {2'b00, len}) begin
					kind = `OTPC_K_DOUT;
					didx = idx_ff[2:0] - 3'd4;
				end
			end
			`OTPC_OP_PROG, `OTPC_OP_PROT: begin
				if (idx_ff == 5'd0) begin
					kind = `OTPC_K_CMD;
					sbyte = `OTPC_CMD_PROG;
				end else if (idx_ff < 5'd6) begin
					kind = `OTPC_K_ADDR;
					sbyte = abyte;
				end else if (op_ff == `OTPC_OP_PROT && idx_ff == 5'd6) begin
					kind = `OTPC_K_DIN;
					sbyte = `OTPC_BYTE_ZERO;
				end else if (op_ff == `OTPC_OP_PROG && idx_ff < 5'd6 + {2'b00, len}) begin
					kind = `OTPC_K_DIN;
					didx = idx_ff[2:0] - 3'd6;
					sbyte = wdata[{didx[1:0], 3'b000} +: 8];
				end else begin
					// Tail after the data: confirm, wait, then fetch pass or fail.
					case (idx_ff - ((op_ff == `OTPC_OP_PROT) ? 5'd7 : 5'd6 + {2'b00, len}))
						5'd0: begin
							kind = `OTPC_K_CMD;
							sbyte = `OTPC_CMD_PROG_GO;
						end
						5'd1: kind = `OTPC_K_WAIT;
						5'd2: begin
							kind = `OTPC_K_CMD;
							sbyte = `OTPC_CMD_STATUS;
						end
						5'd3: begin
							kind = `OTPC_K_DOUT;
							is_stat = 1'b1;
						end
						default: kind = `OTPC_K_END;
					endcase
				end
			end
			default: kind = `OTPC_K_END;
		endcase
	end

	// Guards checked when software starts an operation. There is no erase operation at all.
	always @* begin
		needs_otp = (op == `OTPC_OP_READ) || (op == `OTPC_OP_PROG) ||
			(op == `OTPC_OP_PROT) || (op == `OTPC_OP_COLRD);
		refuse = 1'b0;
		if (needs_otp && !otp_mode_ff) begin
			refuse = 1'b1;
		end
		if (op == `OTPC_OP_PROG) begin
			if (page < `OTPC_FIRST_PAGE || page >= `OTPC_FIRST_PAGE + `OTPC_NUM_PAGES) begin
				refuse = 1'b1;
			end
			if (prog_seen_ff && page < last_page_ff) begin
				refuse = 1'b1;
			end
			if (prog_seen_ff && page == last_page_ff && part_cnt_ff >= `OTPC_PARTIAL_LIMIT) begin
				refuse = 1'b1;
			end
		end
		if ((op == `OTPC_OP_READ || op == `OTPC_OP_COLRD) && (len == 3'h0 || len > 3'h4)) begin
			refuse = 1'b1;
		end
		if (op == `OTPC_OP_PROG && (len == 3'h0 || len > 3'h4)) begin
			refuse = 1'b1;
		end
		if (op == 4'h0 || op > `OTPC_OP_SRESET) begin
			refuse = 1'b1;
		end
	end

	// Sequencer state transitions.
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE: begin
				if (go && !refuse) begin
					nxt_state = S_ISSUE;
				end
			end
			S_ISSUE: begin
				if (kind == `OTPC_K_END) begin
					nxt_state = S_IDLE;
				end else if (kind == `OTPC_K_WAIT) begin
					nxt_state = S_BUSY;
				end else if (!cg_busy) begin
					nxt_state = S_XFER;
				end
			end
			S_XFER: begin
				if (cg_done) begin
					nxt_state = S_ISSUE;
				end
			end
			S_BUSY: begin
				// The device may take a while to pull ready/busy low, so it is ignored at first.
				if (wb_ff == 4'h0 && rb_n) begin
					nxt_state = S_ISSUE;
				end
			end
			default: nxt_state = S_IDLE;
		endcase
	end

	// Sequencer registers and the host's view of the OTP area.
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= S_IDLE;
			idx_ff <= 5'd0;
			op_ff <= 4'h0;
			wb_ff <= 4'h0;
			otp_mode_ff <= 1'b0;
			protected_ff <= 1'b0;
			refused_ff <= 1'b0;
			done_ff <= 1'b0;
			nand_stat_ff <= 8'h00;
			rdata_ff <= 32'h0000_0000;
			last_page_ff <= 8'h00;
			part_cnt_ff <= 4'h0;
			prog_seen_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			case (state_ff)
				S_IDLE: begin
					if (go) begin
						refused_ff <= refuse;
						done_ff <= refuse;
						op_ff <= op;
						idx_ff <= 5'd0;
						if (!refuse && op == `OTPC_OP_PROG) begin
							// Count every partial program sent to a page, pass or fail.
							prog_seen_ff <= 1'b1;
							last_page_ff <= page;
							part_cnt_ff <= (prog_seen_ff && page == last_page_ff) ?
								part_cnt_ff + 4'h1 : 4'h1;
						end
						if (!refuse && (op == `OTPC_OP_READ || op == `OTPC_OP_COLRD)) begin
							// Undefined data from a bad page must not mix with old bytes.
							rdata_ff <= 32'h0000_0000;
						end
					end
				end
				S_ISSUE: begin
					if (kind == `OTPC_K_END) begin
						done_ff <= 1'b1;
						// Mode tracking follows what the device does at the end of each operation.
						if (op_ff == `OTPC_OP_ENTER) begin
							otp_mode_ff <= 1'b1;
						end else if (op_ff == `OTPC_OP_EXIT) begin
							otp_mode_ff <= 1'b0;
						end else if (op_ff == `OTPC_OP_RESET || op_ff == `OTPC_OP_SRESET) begin
							otp_mode_ff <= 1'b0;
						end else if (op_ff == `OTPC_OP_PROT && !nand_stat_ff[0]) begin
							protected_ff <= 1'b1;
						end
					end else if (kind == `OTPC_K_WAIT) begin
						wb_ff <= WB_LAST;
					end
				end
				S_XFER: begin
					if (cg_done) begin
						idx_ff <= idx_ff + 5'd1;
						if (kind == `OTPC_K_DOUT && is_stat) begin
							// Holds fail in bit 0, ready in bit 6, write protect in bit 7.
							nand_stat_ff <= cg_rbyte;
						end else if (kind == `OTPC_K_DOUT) begin
							rdata_ff[{didx[1:0], 3'b000} +: 8] <= cg_rbyte;
						end
					end
				end
				S_BUSY: begin
					if (wb_ff != 4'h0) begin
						wb_ff <= wb_ff - 4'h1;
					end else if (rb_n) begin
						idx_ff <= idx_ff + 5'd1;
					end
				end
				default: begin
				end
			endcase
		end
	end
endmodule // otpc_ctrl

// File: otpc_regs.vh
// Constants for the OTP area controller: register map, NAND commands, OTP layout and timing.
`ifndef OTPC_REGS_VH
`define OTPC_REGS_VH
// APB register byte offsets.
`define OTPC_REG_CTRL 8'h00
`define OTPC_REG_ADDR 8'h04
`define OTPC_REG_WDATA 8'h08
`define OTPC_REG_LEN 8'h0c
`define OTPC_REG_STAT 8'h10
`define OTPC_REG_RDATA 8'h14
// Control register fields.
`define OTPC_CTRL_GO 4
// Operation codes written to control bits [3:0].
`define OTPC_OP_ENTER 4'h1
`define OTPC_OP_EXIT 4'h2
`define OTPC_OP_READ 4'h3
`define OTPC_OP_PROG 4'h4
`define OTPC_OP_PROT 4'h5
`define OTPC_OP_STAT 4'h6
`define OTPC_OP_COLRD 4'h7
`define OTPC_OP_RESET 4'h8
`define OTPC_OP_SRESET 4'h9
// NAND command and parameter bytes.
`define OTPC_CMD_READ 8'h00
`define OTPC_CMD_READ_GO 8'h30
`define OTPC_CMD_PROG 8'h80
`define OTPC_CMD_PROG_GO 8'h10
`define OTPC_CMD_SETFEAT 8'hef
`define OTPC_FEAT_OTP 8'h90
`define OTPC_P1_ON 8'h01
`define OTPC_BYTE_ZERO 8'h00
`define OTPC_CMD_STATUS 8'h70
`define OTPC_CMD_RESET 8'hff
`define OTPC_CMD_SRESET 8'hfc
`define OTPC_CMD_COLRD 8'h05
`define OTPC_CMD_COLRD_GO 8'he0
// OTP area layout.
`define OTPC_PROT_PAGE 8'h01
`define OTPC_FIRST_PAGE 8'h02
`define OTPC_NUM_PAGES 8'h1e
`define OTPC_PARTIAL_LIMIT 4'h8
`define OTPC_ARRAY_READY_BIT 6
// Bus cycle timing, in ns, and derived clock counts.
`define OTPC_CLK_NS 10
`define OTPC_T_PULSE_NS 30
`define OTPC_T_HOLD_NS 20
`define OTPC_T_BUSY_START_NS 100
`define OTPC_PULSE_CYC ((`OTPC_T_PULSE_NS + `OTPC_CLK_NS - 1) / `OTPC_CLK_NS)
`define OTPC_HOLD_CYC ((`OTPC_T_HOLD_NS + `OTPC_CLK_NS - 1) / `OTPC_CLK_NS)
`define OTPC_BUSY_START_CYC ((`OTPC_T_BUSY_START_NS + `OTPC_CLK_NS - 1) / `OTPC_CLK_NS)
// Step kinds of the command sequencer.
`define OTPC_K_CMD 3'h0
`define OTPC_K_ADDR 3'h1
`define OTPC_K_DIN 3'h2
`define OTPC_K_DOUT 3'h3
`define OTPC_K_WAIT 3'h4
`define OTPC_K_END 3'h5
`endif

// File: otpc_bus_cycle.v
// One asynchronous NAND bus cycle: command, address, data in or data out.
`timescale 1ns/10ps
`include "otpc_regs.vh"
module otpc_bus_cycle (
	// Clock and reset.
	input wire ref_clk,
	input wire rst_b,
	// Request from the sequencer.
	input wire start,
	input wire [2:0] kind,
	input wire [7:0] wbyte,
	output wire busy,
	output reg done_ff,
	output reg [7:0] rbyte_ff,
	// NAND pins.
	output reg cle_ff,
	output reg ale_ff,
	output reg we_n_ff,
	output reg re_n_ff,
	output reg [7:0] dq_o_ff,
	output reg dq_oe_ff,
	input wire [7:0] dq_i
);
	localparam integer LOW_N = `OTPC_PULSE_CYC - 1; // Strobe low length minus one.
	localparam integer HIGH_N = `OTPC_HOLD_CYC - 1; // Strobe high length minus one.
	localparam [3:0] LOW_LAST = LOW_N[3:0]; // Cut to the counter width.
	localparam [3:0] HIGH_LAST = HIGH_N[3:0]; // Cut to the counter width.
	localparam [2:0] PH_SETUP = 3'b001; // Latches and data set up, strobe high.
	localparam [2:0] PH_LOW = 3'b010; // Strobe low.
	localparam [2:0] PH_HIGH = 3'b100; // Strobe high again, hold time.
	reg active_ff; // A cycle is in progress.
	reg [2:0] phase_ff; // One-hot phase.
	reg [3:0] cnt_ff; // Cycles left in the phase.
	reg out_ff; // The cycle reads data from the device.

	assign busy = active_ff;

	// The setup phase keeps the latch enables ahead of the strobe edge, which the device needs.
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			active_ff <= 1'b0;
			phase_ff <= PH_SETUP;
			cnt_ff <= 4'h0;
			out_ff <= 1'b0;
			done_ff <= 1'b0;
			rbyte_ff <= 8'h00;
			cle_ff <= 1'b0;
			ale_ff <= 1'b0;
			we_n_ff <= 1'b1;
			re_n_ff <= 1'b1;
			dq_o_ff <= 8'h00;
			dq_oe_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (!active_ff) begin
				// Idle: accept a new cycle.
				if (start) begin
					active_ff <= 1'b1;
					phase_ff <= PH_SETUP;
					out_ff <= (kind == `OTPC_K_DOUT);
					cle_ff <= (kind == `OTPC_K_CMD);
					ale_ff <= (kind == `OTPC_K_ADDR);
					dq_o_ff <= wbyte;
					dq_oe_ff <= (kind != `OTPC_K_DOUT);
				end
			end else begin
				case (phase_ff)
					PH_SETUP: begin
						phase_ff <= PH_LOW;
						cnt_ff <= LOW_LAST;
						we_n_ff <= out_ff;
						re_n_ff <= ~out_ff;
					end
					PH_LOW: begin
						if (cnt_ff == 4'h0) begin
							// Read data is sampled just before the read strobe rises.
							if (out_ff) begin
								rbyte_ff <= dq_i;
							end
							we_n_ff <= 1'b1;
							re_n_ff <= 1'b1;
							phase_ff <= PH_HIGH;
							cnt_ff <= HIGH_LAST;
						end else begin
							cnt_ff <= cnt_ff - 4'h1;
						end
					end
					PH_HIGH: begin
						if (cnt_ff == 4'h0) begin
							active_ff <= 1'b0;
							done_ff <= 1'b1;
							cle_ff <= 1'b0;
							ale_ff <= 1'b0;
							dq_oe_ff <= 1'b0;
						end else begin
							cnt_ff <= cnt_ff - 4'h1;
						end
					end
					default: begin
						phase_ff <= PH_SETUP;
						active_ff <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule // otpc_bus_cycle

// File: otpc_apb_regs.v
// APB slave holding the controller's software registers.
`timescale 1ns/10ps
`include "otpc_regs.vh"
module otpc_apb_regs (
	// Clock and reset.
	input wire ref_clk,
	input wire rst_b,
	// APB slave.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	// Register contents to the sequencer.
	output reg [3:0] op_ff,
	output reg go_ff,
	output reg [15:0] col_ff,
	output reg [7:0] page_ff,
	output reg [31:0] wdata_ff,
	output reg [2:0] len_ff,
	// State shown to software.
	input wire [31:0] stat,
	input wire [31:0] rdata
);
	wire wr_en; // Access phase of a write.
	reg mapped; // Address hits a register.

	// Every access completes in its first access cycle.
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;

	// Read mux and decode; unmapped offsets read zero with an error.
	always @* begin
		mapped = 1'b1;
		prdata = 32'h0000_0000;
		case (paddr)
			`OTPC_REG_CTRL: prdata = {28'h000_0000, op_ff};
			`OTPC_REG_ADDR: prdata = {8'h00, page_ff, col_ff};
			`OTPC_REG_WDATA: prdata = wdata_ff;
			`OTPC_REG_LEN: prdata = {29'h0000_0000, len_ff};
			`OTPC_REG_STAT: prdata = stat;
			`OTPC_REG_RDATA: prdata = rdata;
			default: mapped = 1'b0;
		endcase
		pslverr = psel & penable & ~mapped;
	end

	// Register writes; go is a one-cycle pulse from the control write.
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			op_ff <= 4'h0;
			go_ff <= 1'b0;
			col_ff <= 16'h0000;
			page_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			len_ff <= 3'h1;
		end else begin
			go_ff <= 1'b0;
			if (wr_en) begin
				case (paddr)
					`OTPC_REG_CTRL: begin
						op_ff <= pwdata[3:0];
						go_ff <= pwdata[`OTPC_CTRL_GO];
					end
					`OTPC_REG_ADDR: begin
						col_ff <= pwdata[15:0];
						page_ff <= pwdata[23:16];
					end
					`OTPC_REG_WDATA: wdata_ff <= pwdata;
					`OTPC_REG_LEN: len_ff <= pwdata[2:0];
					default: begin
					end
				endcase
			end
		end
	end
endmodule // otpc_apb_regs

// File: otpc_checker.sv
// Checker for the OTP controller flash pins and register bus.
`timescale 1ns/10ps
module otpc_checker (
	// Clock and reset.
	input wire ref_clk,
	input wire rst_b,
	// Register bus.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Flash pins.
	input wire ce_n,
	input wire cle,
	input wire ale,
	input wire we_n,
	input wire re_n,
	input wire wp_n,
	input wire [7:0] dq_o,
	input wire dq_oe,
	input wire [7:0] dq_i,
	input wire rb_n
);
	// One clock domain, so clock and reset are given once.
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Erase makes no sense on the OTP area, so it must never be latched.
	a_no_erase: assert property (cle && !we_n |-> dq_o != 8'h60)
		else $error("erase command on the bus");
	a_no_enh_status: assert property (cle && !we_n |-> dq_o != 8'h78)
		else $error("enhanced status command on the bus");
	a_no_enh_col: assert property (cle && !we_n |-> dq_o != 8'h06)
		else $error("enhanced column change on the bus");
	// A write strobe stays low exactly three cycles.
	a_we_pulse: assert property ($fell(we_n) |-> !we_n [*3] ##1 we_n)
		else $error("write strobe width wrong");
	a_drive_write: assert property (!we_n |-> dq_oe && !ce_n && !(cle && ale))
		else $error("write strobe without bus drive");
	// The flash owns the data lines while the read strobe is low.
	a_read_release: assert property (!re_n |-> !dq_oe && !cle && !ale && !ce_n)
		else $error("bus driven during read strobe");
	a_feat_addr: assert property (cle && $rose(we_n) && dq_o == 8'hef
		|-> ##[1:12] (ale && !we_n && dq_o == 8'h90)) else $error("feature address not 90");
	a_apb_error: assert property (psel && penable && paddr > 8'h14 |-> pslverr && pready)
		else $error("unmapped access not refused");
endmodule // otpc_checker

// File: otpc_nand_model.sv
// Behavioural flash target: OTP area, status and ready/busy.
`timescale 1ns/10ps
module otpc_nand_model #(parameter int RD_CYC = 20, PG_CYC = 60, OB_CYC = 15) (
	// Controller clock, only to time ready/busy.
	input wire ref_clk,
	// Flash pins from the controller.
	input wire ce_n,
	input wire cle,
	input wire ale,
	input wire we_n,
	input wire re_n,
	input wire [7:0] dq_o,
	// Flash outputs.
	output logic [7:0] dq_i,
	output logic rb_n
);
	logic [7:0] mem [0:127]; // 32 pages of 4 bytes; wider columns are not modelled.
	logic [7:0] cbuf [0:3]; // Cache register.
	logic [7:0] cmd, pg, a0, st;
	logic [31:0] pv; // Feature parameters, newest in the low byte.
	logic [1:0] col, ptr;
	logic otp, prot, sout;
	int na, nd;
	time rdy_at;
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		{otp, prot, sout, col, ptr, na, nd, rdy_at} = '0;
		{cmd, pg, a0, pv} = '0;
		st = 8'he0;
		rb_n = 1'b1;
		dq_i = 8'h00;
	end
	// Ready/busy only moves on a clock edge, so the controller sees it settled.
	always @(posedge ref_clk) rb_n <= ($time >= rdy_at);
	// Latch commands, addresses and data on the rising write strobe.
	always @(posedge we_n) if (ce_n === 1'b0) begin
		if (cle) begin
			cmd = dq_o;
			na = 0;
			nd = 0;
			sout = 1'b0;
			case (dq_o)
				8'h80: foreach (cbuf[i]) cbuf[i] = 8'hff;
				8'h10: if (prot || pg > 8'h1f) begin
					st = 8'h60;
					rdy_at = $time + OB_CYC * 10;
				end else begin
					if (pg == 8'h01) prot = 1'b1;
					else for (int i = 0; i < 4; i++) mem[{pg[4:0], 2'(i)}] &= cbuf[i];
					st = 8'he0;
					rdy_at = $time + PG_CYC * 10;
				end
				8'h30: begin
					ptr = col;
					rdy_at = $time + RD_CYC * 10;
				end
				8'h70: sout = 1'b1;
				8'he0: ptr = col;
				8'hff, 8'hfc: begin
					otp = 1'b0;
					rdy_at = $time + OB_CYC * 10;
				end
				default: ;
			endcase
		end else if (ale) begin
			if (na == 0) a0 = dq_o;
			if (na == 0) col = dq_o[1:0];
			if (na == 2) pg = dq_o;
			na++;
		end else if (cmd == 8'hef) begin
			pv = {pv[23:0], dq_o};
			nd++;
			if (nd == 4 && a0 == 8'h90) begin
				otp = (pv == 32'h01000000);
				rdy_at = $time + OB_CYC * 10;
			end
		end else begin
			cbuf[col] = dq_o;
			col = col + 2'h1;
		end
	end
	// Status mirrors ready/busy; beyond-range pages give garbage.
	always @(negedge re_n) if (ce_n === 1'b0)
		dq_i = sout ? {st[7], rb_n, st[5:0]} : (pg > 8'h1f ? ~dq_i : mem[{pg[4:0], ptr}]);
	// Hold is over at the rising strobe, so the lines stop showing the byte.
	always @(posedge re_n) begin
		ptr = sout ? ptr : ptr + 2'h1;
		dq_i = ~dq_i;
	end
endmodule // otpc_nand_model

// File: tb_top.sv
// Self-checking bench for the OTP area controller.
`timescale 1ns/10ps
`include "otpc_regs.vh"
module tb_top;
	// One operation with its expected status bits and read data.
	typedef struct packed {
		logic [3:0] op;
		logic [7:0] pg;
		logic [7:0] col;
		logic [31:0] wd;
		logic [2:0] len;
		logic [31:0] sm;
		logic [31:0] se;
		logic [31:0] re;
	} otpc_row_t;
	logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, q;
	wire [31:0] prdata;
	wire [7:0] dq_o, dq_i;
	wire pready, pslverr, ce_n, cle, ale, we_n, re_n, wp_n, dq_oe, rb_n;
	int mismatches = 0, tests_run = 0;
	otpc_row_t rows [21], p;
	always #5 ref_clk = ~ref_clk;
	otpc_ctrl i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
		.wp_n(wp_n), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .rb_n(rb_n));
	otpc_nand_model i_nand (.ref_clk(ref_clk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.re_n(re_n), .dq_o(dq_o), .dq_i(dq_i), .rb_n(rb_n));
	// Compare one word and count it.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus transfer; an idle edge first keeps psel from toggling in one step.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// Load the registers, start, poll for done, then check the results.
	task automatic run(input otpc_row_t r);
		int n;
		apb(1'b1, `OTPC_REG_ADDR, {8'h00, r.pg, 8'h00, r.col});
		apb(1'b1, `OTPC_REG_LEN, {29'h0, r.len});
		apb(1'b1, `OTPC_REG_WDATA, r.wd);
		apb(1'b1, `OTPC_REG_CTRL, {28'h1, r.op});
		n = 0;
		do begin
			apb(1'b0, `OTPC_REG_STAT, 32'h0);
			n++;
		end while (q[2] !== 1'b1 && n < 2000);
		chk({31'h0, q[2]}, 32'h1);
		chk(q & r.sm, r.se);
		if ((r.op == 4'h3 || r.op == 4'h7) && r.se[3] == 1'b0) begin
			apb(1'b0, `OTPC_REG_RDATA, 32'h0);
			chk(q, r.re);
		end
	endtask
	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// A hang is cut off well beyond the expected run of some 3000 cycles.
	initial begin
		#600000;
		mismatches++;
		print_verdict();
	end
	initial begin
		rows = '{
			'{4'h3, 8'h02, 8'h00, 32'h0, 3'h4, 32'ha, 32'h8, 32'h0},
			'{4'h1, 8'h00, 8'h00, 32'h0, 3'h1, 32'ha, 32'h2, 32'h0},
			'{4'h3, 8'h02, 8'h00, 32'h0, 3'h4, 32'hff00000a, 32'he0000002, 32'hffffffff},
			'{4'h4, 8'h02, 8'h00, 32'h12345678, 3'h4, 32'hff00000a, 32'he0000002, 32'h0},
			'{4'h4, 8'h02, 8'h00, 32'hffff00ff, 3'h4, 32'ha, 32'h2, 32'h0},
			'{4'h3, 8'h02, 8'h00, 32'h0, 3'h4, 32'ha, 32'h2, 32'h12340078},
			'{4'h7, 8'h02, 8'h02, 32'h0, 3'h2, 32'ha, 32'h2, 32'h1234},
			'{4'h4, 8'h03, 8'h00, 32'hffffffff, 3'h1, 32'ha, 32'h2, 32'h0},
			'{4'h4, 8'h02, 8'h00, 32'h0, 3'h1, 32'ha, 32'ha, 32'h0},
			'{4'h4, 8'h20, 8'h00, 32'h0, 3'h1, 32'ha, 32'ha, 32'h0},
			'{4'h5, 8'h00, 8'h00, 32'h0, 3'h1, 32'hff00001a, 32'he0000012, 32'h0},
			'{4'h4, 8'h04, 8'h00, 32'h0, 3'h1, 32'hff00001a, 32'h60000012, 32'h0},
			'{4'h5, 8'h00, 8'h00, 32'h0, 3'h1, 32'hff00001a, 32'h60000012, 32'h0},
			'{4'h3, 8'h04, 8'h00, 32'h0, 3'h4, 32'h1a, 32'h12, 32'hffffffff},
			'{4'h2, 8'h00, 8'h00, 32'h0, 3'h1, 32'ha, 32'h0, 32'h0},
			'{4'h1, 8'h00, 8'h00, 32'h0, 3'h1, 32'ha, 32'h2, 32'h0},
			'{4'h8, 8'h00, 8'h00, 32'h0, 3'h1, 32'ha, 32'h0, 32'h0},
			'{4'h1, 8'h00, 8'h00, 32'h0, 3'h1, 32'ha, 32'h2, 32'h0},
			'{4'h9, 8'h00, 8'h00, 32'h0, 3'h1, 32'ha, 32'h0, 32'h0},
			'{4'h1, 8'h00, 8'h00, 32'h0, 3'h1, 32'ha, 32'h2, 32'h0},
			'{4'h6, 8'h00, 8'h00, 32'h0, 3'h1, 32'h4000000a, 32'h40000002, 32'h0}};
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		apb(1'b0, `OTPC_REG_LEN, 32'h0);
		chk(q, 32'h1);
		apb(1'b1, 8'h20, 32'h5);
		chk({31'h0, err}, 32'h1);
		foreach (rows[i]) run(rows[i]);
		// Eight partial programs to one page pass the guard; the ninth is refused.
		p = '{4'h4, 8'h05, 8'h00, 32'h0, 3'h1, 32'ha, 32'h2, 32'h0};
		repeat (8) run(p);
		p.se = 32'ha;
		run(p);
		// Reset in the middle of an operation must drop chip enable and clear status.
		apb(1'b1, `OTPC_REG_CTRL, {28'h1, 4'h1});
		repeat (30) @(posedge ref_clk);
		rst_b <= 1'b0;
		@(posedge ref_clk);
		chk({30'h0, ce_n, wp_n}, 32'h3);
		rst_b <= 1'b1;
		apb(1'b0, `OTPC_REG_STAT, 32'h0);
		chk(q, 32'h0);
		print_verdict();
	end
endmodule // tb_top
bind otpc_ctrl otpc_checker i_chk (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
	.re_n(re_n), .wp_n(wp_n), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .rb_n(rb_n));
